// ==== hw/afo_ctrl.v ====
// How it works
// - four overflow flags, one per sequencer FIFO, bits 3..0; upper bits read zero
// - writing one to a flag bit clears it; flags reset to zero
// - trigger select register picks the starting event for every sequencer
// - each sequencer has its own independent four-bit trigger field
`timescale 1ns/1ps
`default_nettype none
`include "afo_defs.vh"
module afo_ctrl (
  input wire hclk, // bus clock
  input wire hresetn, // async reset, active low
  input wire hsel, // slave select
  input wire [11:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size
  input wire hready, // bus ready in
  input wire [31:0] hwdata, // write data
  output reg [31:0] hrdata, // read data
  output reg hreadyout, // slave ready
  output reg hresp, // always okay
  input wire [3:0] seq_fifo_wr, // per-sequencer fifo write request
  input wire [3:0] seq_fifo_full, // per-sequencer fifo full
  output reg [3:0] seq_fifo_wr_ok, // write accepted by fifo
  input wire [15:0] trig_event, // event lines, each sequencer picks one of 0..14 by its 4-bit code
  output reg [3:0] seq_trigger, // selected trigger per sequencer
  output reg [15:0] trig_select, // trigger select fields
  output reg irq // level interrupt
);
  // ****************************************
  // bus front end
  // ****************************************
  reg dp_wr;
  reg dp_rd;
  reg [11:0] dp_addr;
  wire ap_valid = hsel && hready && htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 12'h000;
    end else begin
      dp_wr <= ap_valid && hwrite;
      dp_rd <= ap_valid && !hwrite;
      if (ap_valid) begin
        dp_addr <= haddr;
      end
    end
  end
  wire wr_ovf = dp_wr && (dp_addr == `AFO_OFS_OVERFLOW);
  wire wr_trig = dp_wr && (dp_addr == `AFO_OFS_TRIGSEL);
  wire wr_mask = dp_wr && (dp_addr == `AFO_OFS_INTMASK);
  // read-to-clear acts on the address phase so the data phase sees the old value
  wire rd_stat = ap_valid && !hwrite && (haddr == `AFO_OFS_INTSTAT);
  // ****************************************
  // event input synchroniser
  // ****************************************
  // event lines come from pins and other clocks; two stages before any use
  reg [15:0] trig_meta;
  reg [15:0] trig_sync;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_meta <= 16'h0000;
      trig_sync <= 16'h0000;
    end else begin
      trig_meta <= trig_event;
      trig_sync <= trig_meta;
    end
  end
  // ****************************************
  // overflow flags and fifo write gating
  // ****************************************
  reg [3:0] ovf;
  reg [3:0] int_stat;
  reg [3:0] int_mask;
  wire [3:0] ovf_evt = seq_fifo_wr & seq_fifo_full;
  genvar i;
  generate
    for (i = 0; i < `AFO_NSEQ; i = i + 1) begin : g_seq
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ovf[i] <= 1'b0;
          int_stat[i] <= 1'b0;
          seq_fifo_wr_ok[i] <= 1'b0;
          seq_trigger[i] <= 1'b0;
        end else begin
          // a new overflow in the clearing cycle wins over the clear
          if (ovf_evt[i]) begin
            ovf[i] <= 1'b1;
          end else if (wr_ovf && hwdata[i]) begin
            ovf[i] <= 1'b0;
          end
          if (ovf_evt[i]) begin
            int_stat[i] <= 1'b1;
          end else if (rd_stat) begin
            int_stat[i] <= 1'b0;
          end
          // dropped write never reaches the fifo, so stored data stays intact
          seq_fifo_wr_ok[i] <= seq_fifo_wr[i] && !seq_fifo_full[i];
          case (trig_select[i*4 +: 4])
            `AFO_TRIG_ALWAYS: seq_trigger[i] <= 1'b1;
            default: seq_trigger[i] <= trig_sync[trig_select[i*4 +: 4]];
          endcase
        end
      end
    end
  endgenerate
  // ****************************************
  // writable registers
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_select <= `AFO_RST_TRIGSEL;
      int_mask <= `AFO_RST_MASK;
      irq <= 1'b0;
    end else begin
      if (wr_trig) begin
        trig_select <= hwdata[15:0];
      end
      if (wr_mask) begin
        int_mask <= hwdata[3:0];
      end
      irq <= |(int_stat & int_mask);
    end
  end
  // ****************************************
  // read data, registered at the address phase
  // ****************************************
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (haddr)
      `AFO_OFS_OVERFLOW: next_rdata = {28'h0000000, ovf};
      `AFO_OFS_TRIGSEL: next_rdata = {16'h0000, trig_select};
      `AFO_OFS_INTSTAT: next_rdata = {28'h0000000, int_stat};
      `AFO_OFS_INTMASK: next_rdata = {28'h0000000, int_mask};
      default: next_rdata = 32'h00000000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_valid && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/afo_defs.vh ====
`ifndef AFO_DEFS_VH
`define AFO_DEFS_VH
// ****************************************
// register map
// ****************************************
`define AFO_OFS_OVERFLOW 12'h010
`define AFO_OFS_TRIGSEL 12'h014
`define AFO_OFS_INTSTAT 12'h020
`define AFO_OFS_INTMASK 12'h024
// ****************************************
// fields and reset values
// ****************************************
`define AFO_NSEQ 4
`define AFO_TRIG_W 4
`define AFO_TRIGSEL_W 16
`define AFO_RST_OVERFLOW 4'h0
`define AFO_RST_TRIGSEL 16'h0000
`define AFO_RST_MASK 4'h0
`define AFO_TRIG_ALWAYS 4'hf
`define AFO_HTRANS_NONSEQ 2'b10
`endif

// ==== sim/afo_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module afo_chk (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic [3:0] seq_fifo_wr, // write req
  input wire logic [3:0] seq_fifo_full, // full
  input wire logic [3:0] seq_fifo_wr_ok, // taken
  input wire logic [15:0] trig_event, // events
  input wire logic [3:0] seq_trigger, // picks
  input wire logic [15:0] trig_select, // fields
  input wire logic [31:0] hrdata // read data
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // events pass two sync stages and an output stage, so look three cycles back
  logic [15:0] ev_d1 = 16'h0, ev_d2 = 16'h0, ev_d3 = 16'h0;
  always @(posedge hclk) begin
    ev_d1 <= trig_event;
    ev_d2 <= ev_d1;
    ev_d3 <= ev_d2;
  end
  sequence s_held;
    $stable(trig_select) ##1 $stable(trig_select) ##1 $stable(trig_select);
  endsequence
  property p_hi0; hrdata[31:16] == 16'h0000; endproperty
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  property p_rst; $rose(hresetn) |-> hrdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("read data not clear");
  property p_s0; s_held |-> seq_trigger[0] ==
    (trig_select[3:0] == 4'hf || ev_d3[trig_select[3:0]]); endproperty
  a_s0: assert property (p_s0) else $error("trigger 0 wrong");
  property p_s3; s_held |-> seq_trigger[3] ==
    (trig_select[15:12] == 4'hf || ev_d3[trig_select[15:12]]); endproperty
  a_s3: assert property (p_s3) else $error("trigger 3 wrong");
  property p_drop; |seq_fifo_wr |=>
    seq_fifo_wr_ok == $past(seq_fifo_wr & ~seq_fifo_full); endproperty
  a_drop: assert property (p_drop) else $error("full write passed");
  cover property (|(seq_fifo_wr & seq_fifo_full));
  cover property (seq_trigger[3]);
  cover property ($fell(|seq_fifo_wr_ok));
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "afo_defs.vh"
module tb_top;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [11:0] haddr = 12'h0;
  logic [31:0] hwdata = 32'h0, q;
  logic [3:0] wr = 4'h0, full = 4'h0;
  logic [15:0] ev = 16'h0;
  wire [31:0] hrdata;
  wire [15:0] tsel;
  wire [3:0] ok, trg;
  wire hreadyout, hresp, irq;
  int bad_count = 0, n_tests = 0, cyc = 0;
  afo_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .seq_fifo_wr(wr),
    .seq_fifo_full(full), .seq_fifo_wr_ok(ok), .trig_event(ev), .seq_trigger(trg),
    .trig_select(tsel), .irq(irq));
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      report_and_stop;
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= `AFO_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk("hrdata", e, q);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(`AFO_OFS_OVERFLOW, 32'h0);
    rd(`AFO_OFS_TRIGSEL, 32'h0);
    xfer(1'h1, `AFO_OFS_TRIGSEL, 32'hffff_f501);
    rd(`AFO_OFS_TRIGSEL, 32'h0000_f501);
    chk("trig_select", 32'hf501, tsel);
    chk("hresp", 32'h0, hresp);
    ev <= 16'h0022;
    repeat (3) @(posedge hclk);
    #1 chk("seq_trigger", 32'hd, trg);
    @(posedge hclk);
    full <= 4'h5;
    wr <= 4'hf;
    @(posedge hclk);
    wr <= 4'h0;
    #1 chk("wr_ok", 32'ha, ok);
    @(posedge hclk);
    rd(`AFO_OFS_OVERFLOW, 32'h5);
    xfer(1'h1, `AFO_OFS_INTMASK, 32'h1);
    @(posedge hclk);
    #1 chk("irq", 32'h1, irq);
    @(posedge hclk);
    rd(`AFO_OFS_INTSTAT, 32'h5);
    #1 chk("irq", 32'h0, irq);
    @(posedge hclk);
    xfer(1'h1, `AFO_OFS_OVERFLOW, 32'h1);
    rd(`AFO_OFS_OVERFLOW, 32'h4);
    xfer(1'h1, `AFO_OFS_OVERFLOW, 32'hffff_ffff);
    rd(`AFO_OFS_OVERFLOW, 32'h0);
    rd(12'h100, 32'h0);
    report_and_stop;
  end
endmodule
bind afo_ctrl afo_chk u_chk (.hclk(hclk), .hresetn(hresetn), .seq_fifo_wr(seq_fifo_wr),
  .seq_fifo_full(seq_fifo_full), .seq_fifo_wr_ok(seq_fifo_wr_ok), .trig_event(trig_event),
  .seq_trigger(seq_trigger), .trig_select(trig_select), .hrdata(hrdata));
`default_nettype wire
